// File: rtl/dpms_pkg.sv
// Constants shared by the deserializer power mode sequencer
package dpms_pkg;
   localparam int CLK_PERIOD_NS = 100;
   // Enable qualification, both directions
   localparam int T_ENABLE_NS   = 10000;
   localparam int T_PWRDN_NS    = 10000;
   localparam int T_WAKEUP_NS   = 500000;
   localparam int T_SLEEP_NS    = 100000;
   // Link clock slower than 250 kHz falls back to standby: the gap counter times 2000 ns between any two edges
   localparam int F_LINK_MIN_KHZ = 500;
   localparam int T_LINK_MAX_NS  = 1000000 / F_LINK_MIN_KHZ;
   localparam int ENABLE_CYC = (T_ENABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PWRDN_CYC  = (T_PWRDN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKEUP_CYC = T_WAKEUP_NS / CLK_PERIOD_NS;
   localparam int SLEEP_CYC  = T_SLEEP_NS / CLK_PERIOD_NS;
   localparam int LINK_GAP_CYC = T_LINK_MAX_NS / CLK_PERIOD_NS;
   // Link edges needed in standby before waking
   localparam int ACT_EDGES = 4;
   localparam int CNT_W = 16;
   // Clock multiplication per lane count
   localparam logic [4:0] MULT_TWO_LANE = 5'h0F;
   localparam logic [4:0] MULT_ONE_LANE = 5'h1E;
   // Idle output pattern
   localparam logic [23:0] IDLE_COLOUR = 24'hFFFFFF;
   // Register map, byte addresses
   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam int CTRL_FORCE_BIT  = 0;
   localparam int ST_MODE_LSB     = 0;
   localparam int ST_LOCK_BIT     = 4;
   localparam int ST_TWO_LANE_BIT = 5;
   localparam int ST_RELEASED_BIT = 6;
   localparam int ST_ENABLE_BIT   = 7;
   typedef enum logic [2:0] {
      MODE_SHUTDOWN,
      MODE_STANDBY,
      MODE_ACQUIRE,
      MODE_RECEIVE,
      MODE_DRAIN
   } dpms_mode_type;
endpackage

// File: rtl/dpms_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module dpms_pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] level_out
);
   logic [WIDTH-1:0] ff1_r;
   logic [WIDTH-1:0] ff2_r;
   logic [WIDTH-1:0] ff3_r;
   logic [WIDTH-1:0] level_r;
   wire  [WIDTH-1:0] agree = ~(ff2_r ^ ff3_r);
   wire  [WIDTH-1:0] level_nxt = (agree & ff3_r) | (~agree & level_r);

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         ff1_r   <= '0;
         ff2_r   <= '0;
         ff3_r   <= '0;
         level_r <= '0;
      end
      else
      begin
         ff1_r   <= pin_in;
         ff2_r   <= ff1_r;
         ff3_r   <= ff2_r;
         level_r <= level_nxt;
      end
   end

   assign level_out = level_r;
endmodule

// File: rtl/dpms_sequencer.sv
// Operating-mode sequencer of a serial video receiver with Avalon-MM status port
`timescale 1ns/1ps
// Function
// - Leave shutdown only after enable held high longer than 10 us.
// - Standby holds colour and syncs high, data-enable and pixel clock low.
// - Entering standby starts the link clock activity monitor.
// - Link clock activity seen in standby moves to acquire.
// - Acquire enables clock recovery and keeps outputs idle.
// - Lock within the wake-up time moves to receive.
// - After lock enable lane zero alone or both lanes per lane select.
// - First recovered word releases the bus and is driven out.
// - Common mode high means standby request; outputs off within sleep time.
// - Receive to standby goes idle on next recovered clock falling edge.
// - Back in standby clock recovery stops, activity monitor keeps running.
// - Enable low longer than power-down time enters shutdown, outputs idle.
// - Shutdown turns off clock recovery and deserialisation.
// - Link clock below 250 kHz (no edge for 2 us) falls back to standby.
// - Lane select high multiplies link clock by 15, 15 bits per lane.
module dpms_sequencer #(
   parameter int WAKEUP_CYCLES = dpms_pkg::WAKEUP_CYC
) (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        receiver_enable_pin,
   input  wire logic        link_clock_in,
   input  wire logic        clock_common_mode_level,
   input  wire logic        pll_lock_in,
   input  wire logic        pll_clock_in,
   input  wire logic        lane_count_select,
   input  wire logic [23:0] recovered_colour,
   input  wire logic        recovered_vsync,
   input  wire logic        recovered_hsync,
   input  wire logic        recovered_valid,
   input  wire logic        recovered_strobe,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic      [23:0] colour_out,
   output logic             vertical_sync_out,
   output logic             horizontal_sync_out,
   output logic             pixel_valid_out,
   output logic             pixel_clock_out,
   output logic             pll_enable_out,
   output logic             monitor_enable_out,
   output logic             deser_enable_out,
   output logic             serial_lane_zero_enable,
   output logic             serial_lane_one_enable,
   output logic      [4:0]  pll_multiplier_out
);
   localparam int CW = dpms_pkg::CNT_W;
   localparam logic [CW-1:0] ENABLE_MAX = CW'(dpms_pkg::ENABLE_CYC);
   localparam logic [CW-1:0] PWRDN_MAX  = CW'(dpms_pkg::PWRDN_CYC);
   localparam logic [CW-1:0] WAKEUP_MAX = CW'(WAKEUP_CYCLES);
   localparam logic [CW-1:0] SLEEP_MAX  = CW'(dpms_pkg::SLEEP_CYC);
   localparam logic [CW-1:0] GAP_MAX    = CW'(dpms_pkg::LINK_GAP_CYC);
   localparam logic [2:0]    EDGE_MAX   = 3'(dpms_pkg::ACT_EDGES);

   // Raw pins in synchroniser order
   logic [5:0] pins_raw;
   logic [5:0] pins_s;
   assign pins_raw[5] = receiver_enable_pin;
   assign pins_raw[4] = link_clock_in;
   assign pins_raw[3] = clock_common_mode_level;
   assign pins_raw[2] = pll_lock_in;
   assign pins_raw[1] = pll_clock_in;
   assign pins_raw[0] = lane_count_select;

   // Synchronised pins
   dpms_pin_sync #(
      .WIDTH (6)
   ) u_pin_sync (
      .clk       (clk),
      .rstn      (rstn),
      .pin_in    (pins_raw),
      .level_out (pins_s)
   );
   wire enable_s = pins_s[5];
   wire link_s   = pins_s[4];
   wire cm_s     = pins_s[3];
   wire lock_s   = pins_s[2];
   wire pllclk_s = pins_s[1];
   wire lanes_s  = pins_s[0];

   dpms_pkg::dpms_mode_type mode_r;
   dpms_pkg::dpms_mode_type mode_nxt;
   logic [CW-1:0] en_hi_r;
   logic [CW-1:0] en_hi_nxt;
   logic [CW-1:0] en_lo_r;
   logic [CW-1:0] en_lo_nxt;
   logic [CW-1:0] wait_r;
   logic [CW-1:0] wait_nxt;
   logic [CW-1:0] gap_r;
   logic [CW-1:0] gap_nxt;
   logic [2:0]    edges_r;
   logic [2:0]    edges_nxt;
   logic          link_prev_r;
   logic          pllclk_prev_r;
   logic          released_r;
   logic          released_nxt;
   logic          two_lane_r;
   logic          ack_r;
   logic [31:0]   ctrl_r;
   logic [31:0]   readdata_r;
   logic [23:0]   colour_r;
   logic          vsync_r;
   logic          hsync_r;
   logic          valid_r;
   logic          pclk_r;

   // Qualified enable levels
   wire en_on   = (en_hi_r == ENABLE_MAX);
   wire en_off  = (en_lo_r == PWRDN_MAX);
   wire link_edge   = link_s ^ link_prev_r;
   wire pll_fall    = pllclk_prev_r & ~pllclk_s;
   wire link_slow   = (gap_r == GAP_MAX);
   wire force_sb    = ctrl_r[dpms_pkg::CTRL_FORCE_BIT];
   wire sleep_req   = cm_s | link_slow | force_sb;
   wire in_standby  = (mode_r == dpms_pkg::MODE_STANDBY);
   wire in_acquire  = (mode_r == dpms_pkg::MODE_ACQUIRE);
   wire in_receive  = (mode_r == dpms_pkg::MODE_RECEIVE);
   wire in_drain    = (mode_r == dpms_pkg::MODE_DRAIN);
   wire in_shutdown = (mode_r == dpms_pkg::MODE_SHUTDOWN);
   wire wait_done   = (wait_r == '0);

   // Enable qualification counters
   assign en_hi_nxt = !enable_s ? '0 : (en_on ? en_hi_r : en_hi_r + CW'(1));
   assign en_lo_nxt = enable_s ? '0 : (en_off ? en_lo_r : en_lo_r + CW'(1));
   // Link clock gap counter: saturates when no edge for a slow period
   assign gap_nxt = (link_edge || in_shutdown) ? '0 : (link_slow ? gap_r : gap_r + CW'(1));

   // Sync stages reset low while the idle link sits high; that first false edge
   // arrives in shutdown, where the monitor and gap counter are held clear
   // Activity monitor: counts link edges with common mode low
   always_comb
   begin
      edges_nxt = edges_r;
      if (!monitor_enable_out || cm_s || link_slow)
         edges_nxt = '0;
      else if (link_edge && edges_r != EDGE_MAX)
         edges_nxt = edges_r + 3'h1;
   end

   // Mode sequencing
   always_comb
   begin
      mode_nxt     = mode_r;
      wait_nxt     = (wait_r == '0) ? '0 : wait_r - CW'(1);
      released_nxt = released_r;
      case (mode_r)
         dpms_pkg::MODE_SHUTDOWN:
         begin
            released_nxt = 1'b0;
            if (en_on)
               mode_nxt = dpms_pkg::MODE_STANDBY;
         end
         dpms_pkg::MODE_STANDBY:
         begin
            released_nxt = 1'b0;
            if (en_off)
               mode_nxt = dpms_pkg::MODE_SHUTDOWN;
            else if (edges_r == EDGE_MAX && !force_sb)
            begin
               mode_nxt = dpms_pkg::MODE_ACQUIRE;
               wait_nxt = WAKEUP_MAX;
            end
         end
         dpms_pkg::MODE_ACQUIRE:
         begin
            if (en_off)
               mode_nxt = dpms_pkg::MODE_SHUTDOWN;
            else if (sleep_req)
               mode_nxt = dpms_pkg::MODE_STANDBY;
            else if (lock_s)
               mode_nxt = dpms_pkg::MODE_RECEIVE;
            else if (wait_done)
               mode_nxt = dpms_pkg::MODE_STANDBY;
         end
         // Lock loss is handled like a standby request
         dpms_pkg::MODE_RECEIVE:
         begin
            if (en_off)
            begin
               mode_nxt     = dpms_pkg::MODE_SHUTDOWN;
               released_nxt = 1'b0;
            end
            else if (sleep_req || !lock_s)
            begin
               mode_nxt = dpms_pkg::MODE_DRAIN;
               wait_nxt = SLEEP_MAX;
            end
            else if (recovered_strobe)
               released_nxt = 1'b1;
         end
         dpms_pkg::MODE_DRAIN:
         begin
            // Idle on the recovered clock falling edge, bounded by the sleep time
            if (pll_fall || wait_done || en_off)
            begin
               released_nxt = 1'b0;
               mode_nxt     = en_off ? dpms_pkg::MODE_SHUTDOWN : dpms_pkg::MODE_STANDBY;
            end
         end
         default:
         begin
            mode_nxt     = dpms_pkg::MODE_SHUTDOWN;
            released_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         mode_r        <= dpms_pkg::MODE_SHUTDOWN;
         en_hi_r       <= '0;
         en_lo_r       <= '0;
         wait_r        <= '0;
         gap_r         <= '0;
         edges_r       <= '0;
         link_prev_r   <= 1'b0;
         pllclk_prev_r <= 1'b0;
         released_r    <= 1'b0;
      end
      else
      begin
         mode_r        <= mode_nxt;
         en_hi_r       <= en_hi_nxt;
         en_lo_r       <= en_lo_nxt;
         wait_r        <= wait_nxt;
         gap_r         <= gap_nxt;
         edges_r       <= edges_nxt;
         link_prev_r   <= link_s;
         pllclk_prev_r <= pllclk_s;
         released_r    <= released_nxt;
      end
   end

   // Lane count latched at lock
   always_ff @(posedge clk)
   begin
      if (!rstn)
         two_lane_r <= 1'b0;
      else if (in_acquire && lock_s)
         two_lane_r <= lanes_s;
   end

   // Power control outputs
   assign monitor_enable_out = !in_shutdown;
   assign pll_enable_out     = in_acquire || in_receive || in_drain;
   assign deser_enable_out   = in_receive || in_drain;
   assign serial_lane_zero_enable = deser_enable_out;
   assign serial_lane_one_enable  = deser_enable_out && two_lane_r;
   assign pll_multiplier_out = lanes_s ? dpms_pkg::MULT_TWO_LANE
                                       : dpms_pkg::MULT_ONE_LANE;

   // Parallel output bus: idle pattern until released
   wire load_word  = released_nxt && recovered_strobe && in_receive;
   wire go_idle    = !released_nxt;
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         colour_r <= dpms_pkg::IDLE_COLOUR;
         vsync_r  <= 1'b1;
         hsync_r  <= 1'b1;
         valid_r  <= 1'b0;
         pclk_r   <= 1'b0;
      end
      else if (go_idle)
      begin
         colour_r <= dpms_pkg::IDLE_COLOUR;
         vsync_r  <= 1'b1;
         hsync_r  <= 1'b1;
         valid_r  <= 1'b0;
         pclk_r   <= 1'b0;
      end
      else if (load_word)
      begin
         colour_r <= recovered_colour;
         vsync_r  <= recovered_vsync;
         hsync_r  <= recovered_hsync;
         valid_r  <= recovered_valid;
         pclk_r   <= ~pclk_r;
      end
   end

   assign colour_out          = colour_r;
   assign vertical_sync_out   = vsync_r;
   assign horizontal_sync_out = hsync_r;
   assign pixel_valid_out     = valid_r;
   assign pixel_clock_out     = pclk_r;

   // Avalon-MM slave: one wait cycle on every access
   wire access    = avs_read || avs_write;
   wire sel_ctrl  = (avs_address == dpms_pkg::ADDR_CTRL);
   wire sel_stat  = (avs_address == dpms_pkg::ADDR_STATUS);
   wire do_write  = avs_write && ack_r && sel_ctrl;
   wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                          {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   // Only the force-standby bit is writable
   wire [31:0] ctrl_bits = 32'h0000_0001 << dpms_pkg::CTRL_FORCE_BIT;
   wire [31:0] ctrl_nxt = (ctrl_r & ~be_mask) | (avs_writedata & be_mask & ctrl_bits);
   logic [31:0] status_word;
   // Status fields at their package positions; unused bits read zero
   always_comb
   begin
      status_word = 32'h0000_0000;
      status_word[dpms_pkg::ST_MODE_LSB +: 3] = 3'(mode_r);
      status_word[dpms_pkg::ST_LOCK_BIT]      = lock_s;
      status_word[dpms_pkg::ST_TWO_LANE_BIT]  = two_lane_r;
      status_word[dpms_pkg::ST_RELEASED_BIT]  = released_r;
      status_word[dpms_pkg::ST_ENABLE_BIT]    = enable_s;
   end
   wire [31:0] read_mux = sel_ctrl ? ctrl_r : (sel_stat ? status_word : 32'h0000_0000);

   assign avs_waitrequest = access && !ack_r;

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         ack_r      <= 1'b0;
         ctrl_r     <= dpms_pkg::CTRL_RESET;
         readdata_r <= 32'h0000_0000;
      end
      else
      begin
         ack_r <= access && !ack_r;
         if (do_write)
            ctrl_r <= ctrl_nxt;
         if (avs_read && !ack_r)
            readdata_r <= read_mux;
      end
   end

   assign avs_readdata = readdata_r;
endmodule

// File: verif/dpms_sequencer_assertions.sv
// Port-level assertions for the mode sequencer
`timescale 1ns/1ps
module dpms_sequencer_assertions #(
   parameter int WAKEUP_CYCLES = 50
) (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        receiver_enable_pin,
   input wire logic        clock_common_mode_level,
   input wire logic        pll_lock_in,
   input wire logic        lane_count_select,
   input wire logic [23:0] recovered_colour,
   input wire logic        recovered_strobe,
   input wire logic [23:0] colour_out,
   input wire logic        vertical_sync_out,
   input wire logic        horizontal_sync_out,
   input wire logic        pixel_valid_out,
   input wire logic        pixel_clock_out,
   input wire logic        pll_enable_out,
   input wire logic        monitor_enable_out,
   input wire logic        deser_enable_out,
   input wire logic        serial_lane_zero_enable,
   input wire logic        serial_lane_one_enable,
   input wire logic [4:0]  pll_multiplier_out
);
   logic [7:0] hi_r;
   logic [7:0] lo_r;
   logic [10:0] cm_hi_r;
   localparam int SLEEP_LIMIT = dpms_pkg::SLEEP_CYC + 10;
   wire        idle = colour_out == dpms_pkg::IDLE_COLOUR && vertical_sync_out && horizontal_sync_out
                      && !pixel_valid_out && !pixel_clock_out;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // Consecutive cycles of the raw enable pin at each level, saturating
   always_ff @(posedge clk)
   begin
      hi_r <= (!rstn || !receiver_enable_pin) ? 8'h00 : hi_r + {7'h00, hi_r != 8'hFF};
      lo_r <= (!rstn || receiver_enable_pin) ? 8'h00 : lo_r + {7'h00, lo_r != 8'hFF};
      // Cycles the word path stays on with the link common mode raised
      cm_hi_r <= (!rstn || !clock_common_mode_level || !deser_enable_out) ? 11'h000
                 : cm_hi_r + {10'h000, cm_hi_r != 11'h7FF};
   end
   a_idle_when_off: assert property (!$past(pll_enable_out | deser_enable_out) && !pll_enable_out
      && !deser_enable_out |-> idle) else $error("bus not idle with recovery off");
   a_wake_qual: assert property ($rose(monitor_enable_out) |-> hi_r >= dpms_pkg::ENABLE_CYC)
      else $error("left shutdown before enable qualified");
   a_pwrdn_qual: assert property ($fell(monitor_enable_out) |-> lo_r >= dpms_pkg::PWRDN_CYC)
      else $error("shut down before enable low qualified");
   a_lane_pairing: assert property (serial_lane_one_enable |-> serial_lane_zero_enable && deser_enable_out)
      else $error("lane one without lane zero");
   a_mult_select: assert property ($stable(lane_count_select) [*8] |->
      pll_multiplier_out == (lane_count_select ? dpms_pkg::MULT_TWO_LANE : dpms_pkg::MULT_ONE_LANE))
      else $error("multiplier does not follow lane select");
   a_drain_idle: assert property ($fell(deser_enable_out) |-> idle)
      else $error("bus not idle after leaving receive");
   a_sleep_bound: assert property (cm_hi_r <= SLEEP_LIMIT)
      else $error("outputs still on after sleep time");
   a_acquire_entry: assert property ($rose(pll_enable_out) |-> idle && !deser_enable_out)
      else $error("acquire entered with bus active");
   a_word_out: assert property (deser_enable_out && recovered_strobe && pll_lock_in && !clock_common_mode_level
      |=> colour_out == $past(recovered_colour)) else $error("recovered word not driven out");
endmodule
bind dpms_sequencer dpms_sequencer_assertions #(.WAKEUP_CYCLES(WAKEUP_CYCLES)) u_chk (.clk, .rstn,
   .receiver_enable_pin, .clock_common_mode_level, .pll_lock_in, .lane_count_select, .recovered_colour,
   .recovered_strobe, .colour_out, .vertical_sync_out, .horizontal_sync_out, .pixel_valid_out, .pixel_clock_out,
   .pll_enable_out, .monitor_enable_out, .deser_enable_out, .serial_lane_zero_enable, .serial_lane_one_enable,
   .pll_multiplier_out);

// File: verif/dpms_tx_model.sv
// Transmitter model driving the link clock and its common-mode state
`timescale 1ns/1ps
module dpms_tx_model (
   input  wire logic run,
   output logic      link_clock_in,
   output logic      clock_common_mode_level
);
   // Stopped link: the pull-up holds the clock high and lifts common mode
   assign clock_common_mode_level = !run;
   initial
   begin
      link_clock_in = 1'b1;
      #137;
      forever
      begin
         #400;
         link_clock_in = run ? !link_clock_in : 1'b1;
      end
   end
endmodule

// File: verif/test_dpms_sequencer.sv
// Self-checking bench for the mode sequencer
`timescale 1ns/1ps
module test_dpms_sequencer;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        receiver_enable_pin = 1'b0;
   logic        run = 1'b0;
   logic        pll_lock_in = 1'b0;
   logic        pll_clock_in = 1'b0;
   logic        lane_count_select = 1'b0;
   logic [23:0] recovered_colour = 24'h000000;
   logic        recovered_vsync = 1'b0;
   logic        recovered_hsync = 1'b0;
   logic        recovered_valid = 1'b0;
   logic        recovered_strobe = 1'b0;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest, link_clock_in, clock_common_mode_level;
   logic [23:0] colour_out;
   logic        vertical_sync_out, horizontal_sync_out, pixel_valid_out, pixel_clock_out;
   logic        pll_enable_out, monitor_enable_out, deser_enable_out;
   logic        serial_lane_zero_enable, serial_lane_one_enable;
   logic [4:0]  pll_multiplier_out;
   logic [31:0] seed = 32'h1639;
   logic [31:0] got = 32'h0;
   int          mismatches = 0;
   int          compares = 0;
   int          k;
   int          i;

   always #50 clk = ~clk;
   always #300 pll_clock_in = ~pll_clock_in;

   dpms_sequencer #(.WAKEUP_CYCLES(50)) u_dut (.clk, .rstn, .receiver_enable_pin, .link_clock_in,
      .clock_common_mode_level, .pll_lock_in, .pll_clock_in, .lane_count_select, .recovered_colour,
      .recovered_vsync, .recovered_hsync, .recovered_valid, .recovered_strobe, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .colour_out,
      .vertical_sync_out, .horizontal_sync_out, .pixel_valid_out, .pixel_clock_out, .pll_enable_out,
      .monitor_enable_out, .deser_enable_out, .serial_lane_zero_enable, .serial_lane_one_enable,
      .pll_multiplier_out);
   dpms_tx_model u_tx (.run, .link_clock_in, .clock_common_mode_level);

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   function automatic logic [31:0] idle_exp();
      return {4'h0, dpms_pkg::IDLE_COLOUR, 4'hC};
   endfunction

   function automatic logic [4:0] mult_exp(input logic two_lane);
      return two_lane ? dpms_pkg::MULT_TWO_LANE : dpms_pkg::MULT_ONE_LANE;
   endfunction

   task automatic end_sim();
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
      compares++;
      if (g !== e)
      begin
         mismatches++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, what, g, e);
      end
   endtask

   task automatic chk_idle(input string what);
      chk({4'h0, colour_out, vertical_sync_out, horizontal_sync_out, pixel_valid_out, pixel_clock_out}, idle_exp(), what);
   endtask

   task automatic hang(input string what);
      mismatches++;
      $display("[FAIL] %0t timeout %s", $time, what);
      end_sim();
   endtask

   // Holds the request until waitrequest is low at a rising edge
   task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
      bit done;
      done = 1'b0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= we;
      avs_read <= !we;
      for (int n = 0; n < 20 && !done; n++)
      begin
         @(posedge clk);
         done = avs_waitrequest === 1'b0;
         got = avs_readdata;
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (!done)
         hang("bus");
   endtask

   // Polls the status mode field, returns at a falling edge once it matches
   task automatic wait_mode(input logic [2:0] m);
      for (int n = 0; n < 400; n++)
      begin
         bus(1'b0, dpms_pkg::ADDR_STATUS, 32'h0);
         if (got[2:0] === m)
         begin
            @(negedge clk);
            return;
         end
      end
      hang("mode");
   endtask

   initial
   begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      @(negedge clk);
      chk_idle("shutdown bus");
      got = {27'h0, pll_enable_out, monitor_enable_out, deser_enable_out, serial_lane_zero_enable, serial_lane_one_enable};
      chk(got, 32'h0, "shutdown enables");
      bus(1'b1, 4'h8, 32'hFFFFFFFF);
      bus(1'b0, 4'h8, 32'h0);
      chk(got, 32'h0, "unmapped read");
      bus(1'b1, dpms_pkg::ADDR_STATUS, 32'hFFFFFFFF);
      bus(1'b1, dpms_pkg::ADDR_CTRL, 32'h0);
      bus(1'b0, dpms_pkg::ADDR_STATUS, 32'h0);
      chk(got, 32'h0, "status in shutdown");
      receiver_enable_pin <= 1'b1;
      repeat (60) @(posedge clk);
      receiver_enable_pin <= 1'b0;
      repeat (20) @(posedge clk);
      bus(1'b0, dpms_pkg::ADDR_STATUS, 32'h0);
      chk(got, 32'h0, "short enable ignored");
      receiver_enable_pin <= 1'b1;
      wait_mode(dpms_pkg::MODE_STANDBY);
      chk({30'h0, pll_enable_out, monitor_enable_out}, 32'h1, "standby monitor");
      chk_idle("standby bus");
      for (k = 0; k < 2; k++)
      begin
         @(posedge clk);
         pll_lock_in <= 1'b0;
         lane_count_select <= k[0];
         run <= 1'b1;
         wait_mode(dpms_pkg::MODE_ACQUIRE);
         chk({31'h0, pll_enable_out}, 32'h1, "recovery enabled");
         chk_idle("acquire bus");
         @(posedge clk);
         pll_lock_in <= 1'b1;
         wait_mode(dpms_pkg::MODE_RECEIVE);
         got = {25'h0, pll_multiplier_out, serial_lane_zero_enable, serial_lane_one_enable};
         chk(got, {25'h0, mult_exp(k[0]), 1'b1, k[0]}, "lanes");
         chk_idle("before first word");
         for (i = 0; i < 4; i++)
         begin
            @(posedge clk);
            seed = xs(seed);
            recovered_colour <= seed[23:0];
            {recovered_vsync, recovered_hsync, recovered_valid} <= seed[26:24];
            recovered_strobe <= 1'b1;
            @(posedge clk);
            recovered_strobe <= 1'b0;
            @(negedge clk);
            got = {4'h0, colour_out, vertical_sync_out, horizontal_sync_out, pixel_valid_out, pixel_clock_out};
            chk(got, {4'h0, seed[23:0], seed[26:24], ~i[0]}, "word");
         end
         if (k == 0)
         begin
            @(posedge clk);
            run <= 1'b0;
            wait_mode(dpms_pkg::MODE_STANDBY);
            chk_idle("idle after sleep");
            chk({30'h0, pll_enable_out, monitor_enable_out}, 32'h1, "monitor kept");
         end
      end
      bus(1'b1, dpms_pkg::ADDR_CTRL, 32'h0000_0001);
      wait_mode(dpms_pkg::MODE_STANDBY);
      chk_idle("idle after forced standby");
      repeat (40) @(posedge clk);
      bus(1'b0, dpms_pkg::ADDR_STATUS, 32'h0);
      chk({29'h0, got[2:0]}, {29'h0, dpms_pkg::MODE_STANDBY}, "force holds standby");
      bus(1'b0, dpms_pkg::ADDR_CTRL, 32'h0);
      chk(got, 32'h1, "force bit readback");
      bus(1'b1, dpms_pkg::ADDR_CTRL, 32'h0);
      @(posedge clk);
      receiver_enable_pin <= 1'b0;
      wait_mode(dpms_pkg::MODE_SHUTDOWN);
      chk_idle("idle in shutdown");
      got = {27'h0, pll_enable_out, monitor_enable_out, deser_enable_out, serial_lane_zero_enable, serial_lane_one_enable};
      chk(got, 32'h0, "all off");
      end_sim();
   end
endmodule
